// ===== cia_can_irq_filter.sv
// CAN interrupt register and acceptance filters behind a Wishbone slave
//
// Functional notes
// [R1] Bit 31 enables invalid message interrupt
// [R2] Bit 30 enables bus wake interrupt
// [R3] Bits 29, 28 enable bus and system error
// [R4] Bit 27 enables receive overflow interrupt
// [R5] Bits 19, 18 enable mode and timestamp
// [R6] Bits 17, 16 enable receive and transmit buffer
// [R7] Invalid message event sets flag bit 15
// [R8] System error flag clears only by module off
// [R9] Unused interrupt and filter bits read zero
// [R10] Sixteen identical acceptance filter registers
// [R11] Standard identifier bits 31:21 must match
// [R12] Bit 19 selects extended or standard frames
// [R13] Extended identifier bits 17:0 must match
// [R14] Filter writable only while filter disabled
// [R15] Interrupt asserted for any enabled set flag
// [R16] Match needs enable, type and identifier
//
// The register offsets and register access over Wishbone are this design's own decisions.
`include "cia_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module cia_can_irq_filter #(
	parameter int NUM_FILTERS = `CIA_NUM_FILTERS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Controller events
	input wire cia_pkg::cia_evt_t evt_i,
	// Received message for filtering
	input wire logic rx_valid_i,
	input wire cia_pkg::cia_rx_msg_t rx_msg_i,
	// Results and state
	output logic [NUM_FILTERS-1:0] match_o,
	output logic match_valid_o,
	output logic module_on_o,
	output logic [NUM_FILTERS-1:0] filter_enable_o,
	output logic irq_o
);

	//////////////////////////////////////////////////////////////////////
	// Declarations
	cia_pkg::cia_wb_req_t req;
	logic access;
	logic wr_stb;
	logic [31:0] ctl_ff;
	logic [31:0] nxt_ctl;
	logic [NUM_FILTERS-1:0] flt_en_ff;
	logic [NUM_FILTERS-1:0] nxt_flt_en;
	logic [31:0] flt_ff [NUM_FILTERS];
	logic [31:0] nxt_flt [NUM_FILTERS];
	logic ack_ff;
	logic nxt_ack;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic [NUM_FILTERS-1:0] hit;
	logic [NUM_FILTERS-1:0] match_ff;
	logic [NUM_FILTERS-1:0] nxt_match;
	logic match_valid_ff;
	logic nxt_match_valid;
	logic int_wr;
	logic [31:0] int_reg;
	logic irq_int;
	logic flt_sel;
	logic [3:0] flt_idx;
	logic [31:0] flt_en_merged;

	//////////////////////////////////////////////////////////////////////
	// Bus decode
	always_comb begin
		req.adr = adr_i;
		req.dat = dat_i;
		req.sel = sel_i;
		req.we = we_i;
		access = cyc_i && stb_i && !ack_ff;
		wr_stb = access && req.we;
		flt_sel = req.adr[7:6] == 2'(`CIA_OFS_FLT_BASE >> 6);
		flt_idx = req.adr[5:2];
		int_wr = wr_stb && (req.adr == `CIA_OFS_INT);
	end

	//////////////////////////////////////////////////////////////////////
	// Control and filter enable registers
	always_comb begin
		nxt_ctl = ctl_ff;
		nxt_flt_en = flt_en_ff;
		flt_en_merged = cia_pkg::cia_merge(32'(flt_en_ff), req.dat, req.sel);
		if (wr_stb && req.adr == `CIA_OFS_CONTROL) begin
			nxt_ctl = cia_pkg::cia_merge(ctl_ff, req.dat, req.sel) & `CIA_CTL_MASK;
		end
		if (wr_stb && req.adr == `CIA_OFS_FLT_EN) begin
			nxt_flt_en = flt_en_merged[NUM_FILTERS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_ff <= `CIA_CTL_RESET;
			flt_en_ff <= NUM_FILTERS'(`CIA_FLT_EN_RESET);
		end else begin
			ctl_ff <= nxt_ctl;
			flt_en_ff <= nxt_flt_en;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Acceptance filter patterns
	always_comb begin
		for (int n = 0; n < NUM_FILTERS; n++) begin // [R10]
			nxt_flt[n] = flt_ff[n];
			if (wr_stb && flt_sel && flt_idx == 4'(n) && !flt_en_ff[n]) begin // [R14]
				nxt_flt[n] = cia_pkg::cia_merge(flt_ff[n], req.dat, req.sel)
					& `CIA_FLT_IMPL_MASK; // [R9]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		for (int n = 0; n < NUM_FILTERS; n++) begin
			if (rst_i) begin
				flt_ff[n] <= `CIA_FLT_RESET;
			end else begin
				flt_ff[n] <= nxt_flt[n];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Filter comparators
	for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_flt
		cia_filter_match u_match (
			.pattern_i(flt_ff[g]),
			.filter_enable_i(flt_en_ff[g]),
			.msg_i(rx_msg_i),
			.hit_o(hit[g])
		);
	end

	always_comb begin
		nxt_match = match_ff;
		nxt_match_valid = rx_valid_i && ctl_ff[`CIA_CTL_ON_BIT];
		if (nxt_match_valid) begin
			nxt_match = hit; // [R16]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_ff <= '0;
			match_valid_ff <= 1'b0;
		end else begin
			match_ff <= nxt_match;
			match_valid_ff <= nxt_match_valid;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Interrupt register
	cia_irq u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(int_wr),
		.wdat_i(req.dat),
		.sel_i(req.sel),
		.module_on_i(ctl_ff[`CIA_CTL_ON_BIT]),
		.evt_i(evt_i),
		.reg_o(int_reg),
		.irq_o(irq_int)
	);

	//////////////////////////////////////////////////////////////////////
	// Read data and acknowledge
	always_comb begin
		nxt_ack = access;
		nxt_dat = 32'h0000_0000;
		if (access && !req.we) begin
			if (flt_sel) begin
				if (32'(flt_idx) < NUM_FILTERS) begin
					nxt_dat = flt_ff[flt_idx];
				end
			end else begin
				unique case (req.adr)
					`CIA_OFS_CONTROL: nxt_dat = ctl_ff;
					`CIA_OFS_INT: nxt_dat = int_reg; // [R9]
					`CIA_OFS_FLT_EN: nxt_dat = 32'(flt_en_ff);
					`CIA_OFS_MATCH: nxt_dat = 32'(match_ff);
					default: nxt_dat = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Outputs
	assign ack_o = ack_ff;
	assign dat_o = dat_ff;
	assign match_o = match_ff;
	assign match_valid_o = match_valid_ff;
	assign module_on_o = ctl_ff[`CIA_CTL_ON_BIT];
	assign filter_enable_o = flt_en_ff;
	assign irq_o = irq_int;

endmodule : cia_can_irq_filter

`default_nettype wire

// ===== cia_can_irq_filter_props.sv
// Port checks of the CAN irq/filter block
`timescale 1ns/10ps
`default_nettype none
module cia_can_irq_filter_props #(
	parameter int NUM_FILTERS = 16
) (
	// Clock, reset, bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Events, filtering, state
	input wire cia_pkg::cia_evt_t evt_i,
	input wire logic rx_valid_i,
	input wire logic [NUM_FILTERS-1:0] match_o,
	input wire logic match_valid_o,
	input wire logic module_on_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
	property p_int_unused; ack_o && !we_i && adr_i == 8'h04 |-> dat_o[26:20] == 7'h00; endproperty
	a_int_unused: assert property (p_int_unused) else $error("int gap set");
	property p_flt_unused; ack_o && !we_i && adr_i[7:6] == 2'h1 |-> !dat_o[20] && !dat_o[18];
	endproperty
	a_flt_unused: assert property (p_flt_unused) else $error("filter gap set");
	property p_irq_rise; $rose(irq_o) |-> $past(evt_i != '0 || (cyc_i && stb_i && we_i)); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
	property p_mv; rx_valid_i && module_on_o |=> match_valid_o; endproperty
	a_mv: assert property (p_mv) else $error("no match result");
	property p_mv_cause; match_valid_o |-> $past(rx_valid_i && module_on_o); endproperty
	a_mv_cause: assert property (p_mv_cause) else $error("stray match result");
	property p_match_hold; !match_valid_o |-> $stable(match_o); endproperty
	a_match_hold: assert property (p_match_hold) else $error("match moved");
	property p_on_cause; $changed(module_on_o) |-> $past(cyc_i && stb_i && we_i && adr_i == 8'h00);
	endproperty
	a_on_cause: assert property (p_on_cause) else $error("module on moved");
	c_irq: cover property ($rose(irq_o));
	c_hit: cover property (match_valid_o && match_o != '0);
	c_on: cover property ($rose(module_on_o));
endmodule : cia_can_irq_filter_props
bind cia_can_irq_filter cia_can_irq_filter_props #(.NUM_FILTERS(NUM_FILTERS)) u_props (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.we_i(we_i),
	.adr_i(adr_i),
	.dat_o(dat_o),
	.ack_o(ack_o),
	.evt_i(evt_i),
	.rx_valid_i(rx_valid_i),
	.match_o(match_o),
	.match_valid_o(match_valid_o),
	.module_on_o(module_on_o),
	.irq_o(irq_o)
);
`default_nettype wire

// ===== cia_can_node_model.sv
// Model of a remote CAN node handing received identifiers to the block
`timescale 1ns/10ps
`default_nettype none
module cia_can_node_model (
	// Clock
	input wire logic clk_i,
	// Received message
	output logic rx_valid_o,
	output var cia_pkg::cia_rx_msg_t rx_msg_o
);
	initial begin
		rx_valid_o = 1'b0;
		rx_msg_o = '0;
	end
	// One message, then scrambled lines
	task automatic send(input cia_pkg::cia_rx_msg_t m);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_msg_o <= m;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_msg_o <= ~m;
	endtask : send
endmodule : cia_can_node_model
`default_nettype wire

// ===== cia_consts.svh
// Register offsets, field positions, reset values and widths of the CAN irq/filter block
`ifndef CIA_CONSTS_SVH
`define CIA_CONSTS_SVH

// Register byte offsets
`define CIA_OFS_CONTROL 8'h00
`define CIA_OFS_INT 8'h04
`define CIA_OFS_FLT_EN 8'h08
`define CIA_OFS_MATCH 8'h0c
`define CIA_OFS_FLT_BASE 8'h40

// Control register fields
`define CIA_CTL_ON_BIT 15
`define CIA_CTL_MASK 32'h0000_8000
`define CIA_CTL_RESET 32'h0000_0000

// Interrupt register fields
`define CIA_INT_RESET 32'h0000_0000
`define CIA_INT_EN_LSB 16
`define CIA_INT_IMPL_MASK 16'hf80f
`define CIA_INT_SYSERR_BIT 12
`define CIA_INT_BADMSG_BIT 15

// Filter register fields
`define CIA_FLT_SID_MSB 31
`define CIA_FLT_SID_LSB 21
`define CIA_FLT_EXT_BIT 19
`define CIA_FLT_EID_MSB 17
`define CIA_FLT_EID_LSB 0
`define CIA_FLT_IMPL_MASK 32'hffeb_ffff
`define CIA_FLT_RESET 32'h0000_0000

// Sizes
`define CIA_NUM_FILTERS 16
`define CIA_FLT_EN_RESET 16'h0000

`endif

// ===== cia_filter_match.sv
// One acceptance filter comparator
`include "cia_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module cia_filter_match (
	// Filter setting
	input wire logic [31:0] pattern_i,
	input wire logic filter_enable_i,
	// Message under test
	input wire cia_pkg::cia_rx_msg_t msg_i,
	// Result
	output logic hit_o
);

	logic sid_ok;
	logic eid_ok;
	logic type_ok;

	always_comb begin
		sid_ok = pattern_i[`CIA_FLT_SID_MSB:`CIA_FLT_SID_LSB] == msg_i.standard_identifier; // [R11]
		eid_ok = pattern_i[`CIA_FLT_EID_MSB:`CIA_FLT_EID_LSB] == msg_i.extended_identifier; // [R13]
		type_ok = pattern_i[`CIA_FLT_EXT_BIT] == msg_i.ext_frame; // [R12]
		hit_o = filter_enable_i && sid_ok && eid_ok && type_ok; // [R16]
	end

endmodule : cia_filter_match

`default_nettype wire

// ===== cia_irq.sv
// Interrupt enables, sticky flags and interrupt output
`include "cia_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module cia_irq (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register write
	input wire logic wr_i,
	input wire logic [31:0] wdat_i,
	input wire logic [3:0] sel_i,
	// Controller state and events
	input wire logic module_on_i,
	input wire cia_pkg::cia_evt_t evt_i,
	// Register view and interrupt
	output logic [31:0] reg_o,
	output logic irq_o
);

	logic [15:0] en_ff;
	logic [15:0] flag_ff;
	logic irq_ff;
	logic [15:0] nxt_en;
	logic [15:0] nxt_flag;
	logic nxt_irq;
	logic [15:0] set_v;
	logic [15:0] clr_v;
	logic [31:0] merged;

	//////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		set_v = 16'h0000;
		set_v[15] = evt_i.bad_msg; // [R7]
		set_v[14] = evt_i.bus_wake;
		set_v[13] = evt_i.bus_error;
		set_v[12] = evt_i.system_error;
		set_v[11] = evt_i.rx_overflow;
		set_v[3] = evt_i.mode_change;
		set_v[2] = evt_i.timestamp;
		set_v[1] = evt_i.rx_buffer;
		set_v[0] = evt_i.tx_buffer;
		merged = cia_pkg::cia_merge({en_ff, 16'h0000}, wdat_i, sel_i);
		clr_v = 16'h0000;
		if (wr_i) begin
			clr_v = wdat_i[15:0] & {{8{sel_i[1]}}, {8{sel_i[0]}}};
		end
		clr_v[`CIA_INT_SYSERR_BIT] = !module_on_i; // [R8]
		nxt_en = en_ff;
		if (wr_i) begin
			nxt_en = merged[31:16] & `CIA_INT_IMPL_MASK; // [R9]
		end
		nxt_flag = ((flag_ff & ~clr_v) | set_v) & `CIA_INT_IMPL_MASK;
		nxt_irq = |(nxt_flag & nxt_en); // [R1] [R2] [R3] [R4] [R5] [R6] [R15]
	end

	//////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_ff <= 16'(`CIA_INT_RESET >> `CIA_INT_EN_LSB);
			flag_ff <= 16'h0000;
			irq_ff <= 1'b0;
		end else begin
			en_ff <= nxt_en;
			flag_ff <= nxt_flag;
			irq_ff <= nxt_irq;
		end
	end

	assign reg_o = {en_ff, flag_ff};
	assign irq_o = irq_ff;

endmodule : cia_irq

`default_nettype wire

// ===== cia_pkg.sv
// Types and shared functions of the CAN irq/filter block
`default_nettype none

package cia_pkg;

	// Events raised by the rest of the controller, one-cycle pulses
	typedef struct packed {
		logic bad_msg;
		logic bus_wake;
		logic bus_error;
		logic system_error;
		logic rx_overflow;
		logic mode_change;
		logic timestamp;
		logic rx_buffer;
		logic tx_buffer;
	} cia_evt_t;

	// Identifier of a received message
	typedef struct packed {
		logic ext_frame;
		logic [10:0] standard_identifier;
		logic [17:0] extended_identifier;
	} cia_rx_msg_t;

	// Wishbone request fields
	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
	} cia_wb_req_t;

	// Byte-lane merge of write data
	function automatic logic [31:0] cia_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : cia_merge

endpackage : cia_pkg

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the CAN irq/filter block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [3:0] sel_i = 4'h0;
	cia_pkg::cia_evt_t evt_i = '0;
	cia_pkg::cia_rx_msg_t rx_msg_i, m;
	logic rx_valid_i, ack_o, match_valid_o, module_on_o, irq_o;
	logic [15:0] match_o, filter_enable_o;
	int error_cnt = 0, compares = 0, cycles = 0, fb;
	cia_can_irq_filter dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.dat_i(dat_i),
		.sel_i(sel_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.evt_i(evt_i),
		.rx_valid_i(rx_valid_i),
		.rx_msg_i(rx_msg_i),
		.match_o(match_o),
		.match_valid_o(match_valid_o),
		.module_on_o(module_on_o),
		.filter_enable_o(filter_enable_o),
		.irq_o(irq_o)
	);
	cia_can_node_model node (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_msg_o(rx_msg_i));
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		#1;
	endtask : wb
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask : chk_bit
	task automatic tally_and_finish();
		if (error_cnt == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	function automatic logic [31:0] pat(input int n);
		return {11'(n * 5 + 1), 1'b0, 1'(n), 1'b0, 18'(n * 3 + 2)};
	endfunction : pat
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h04, 32'h0, 4'hf);
		chk_val(rd, 32'h0);
		wb(1'b1, 8'h30, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h30, 32'h0, 4'hf);
		chk_val(rd, 32'h0);
		wb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h04, 32'h0, 4'hf);
		chk_val(rd, 32'hf80f_0000);
		chk_bit(irq_o, 1'b0);
		wb(1'b1, 8'h04, 32'h0, 4'hc);
		wb(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
		chk_bit(module_on_o, 1'b1);
		wb(1'b0, 8'h00, 32'h0, 4'hf);
		chk_val(rd, 32'h0000_8000);
		for (int k = 0; k < 9; k++) begin
			fb = (k < 4) ? k : k + 7;
			@(posedge clk_i);
			evt_i <= cia_pkg::cia_evt_t'(9'h001 << k);
			@(posedge clk_i);
			evt_i <= '0;
			#1;
			chk_bit(irq_o, 1'b0);
			wb(1'b0, 8'h04, 32'h0, 4'hf);
			chk_val(rd, 32'h1 << fb);
			wb(1'b1, 8'h04, 32'h1 << (fb + 16), 4'hc);
			chk_bit(irq_o, 1'b1);
			wb(1'b1, 8'h04, 32'h1 << fb, 4'h3);
			chk_bit(irq_o, k == 5);
			wb(1'b1, 8'h04, 32'h0, 4'hc);
			chk_bit(irq_o, 1'b0);
			wb(1'b1, 8'h00, 32'h0, 4'hf);
			chk_bit(module_on_o, 1'b0);
			wb(1'b1, 8'h00, 32'h8000, 4'hf);
			wb(1'b0, 8'h04, 32'h0, 4'hf);
			chk_val(rd, 32'h0);
		end
		wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h40, 32'h0, 4'hf);
		chk_val(rd, 32'hffeb_ffff);
		for (int n = 0; n < 16; n++) begin
			wb(1'b1, 8'h40 + 8'(4 * n), pat(n), 4'hf);
			wb(1'b0, 8'h40 + 8'(4 * n), 32'h0, 4'hf);
			chk_val(rd, pat(n));
		end
		wb(1'b1, 8'h08, 32'hffff, 4'hf);
		chk_val(32'(filter_enable_o), 32'hffff);
		wb(1'b1, 8'h40, 32'h0, 4'hf);
		wb(1'b0, 8'h40, 32'h0, 4'hf);
		chk_val(rd, pat(0));
		for (int n = 0; n < 16; n++) begin
			for (int v = 0; v < 4; v++) begin
				m = {1'(n), 11'(n * 5 + 1), 18'(n * 3 + 2)};
				if (v == 1) m.ext_frame = ~m.ext_frame;
				if (v == 2) m.standard_identifier[n % 11] ^= 1'b1;
				if (v == 3) m.extended_identifier[n] ^= 1'b1;
				node.send(m);
				#1;
				chk_bit(match_valid_o, 1'b1);
				chk_val(32'(match_o), (v == 0) ? 32'h1 << n : 32'h0);
			end
		end
		node.send({1'b1, 11'h01a, 18'h00011});
		wb(1'b0, 8'h0c, 32'h0, 4'hf);
		chk_val(rd, 32'h0000_0020);
		wb(1'b1, 8'h08, 32'hfffe, 4'hf);
		node.send({1'b0, 11'h001, 18'h00002});
		#1;
		chk_val(32'(match_o), 32'h0);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
